// ==== src/atcli_cfg.svh ====
// Purpose: constants for the command line interpreter
// Assumes: 8-bit characters, one clock domain
// Notes:   rule summary follows
// Operation
// - command state treats host characters as commands
// - line is prefix, body, carriage return
// - prefix/names caseless, quoted parameters keep case
// - on-line mode forwards host characters as data
// - escape returns to command, call kept
// - every command line gets a response
// - unsolicited reports sent independent of commands; core sends them only in command mode, outside a response
// - parser always active, reachable via alternate path
// - success code if valid, error otherwise
`ifndef ATCLI_CFG_SVH
`define ATCLI_CFG_SVH

`define ATCLI_CH_CR        8'h0d
`define ATCLI_CH_A         8'h41
`define ATCLI_CH_T         8'h54
`define ATCLI_CH_PLUS      8'h2b
`define ATCLI_CH_QUOTE     8'h22
`define ATCLI_CH_LOW_A     8'h61
`define ATCLI_CH_LOW_Z     8'h7a
`define ATCLI_CASE_OFFSET  8'h20
`define ATCLI_ESC_COUNT    2'h3
`define ATCLI_LINE_DEPTH   64
`define ATCLI_OK_TEXT      48'h0d0a4f4b0d0a
`define ATCLI_OK_LEN       4'h6
`define ATCLI_ERR_TEXT     72'h0d0a4552524f520d0a
`define ATCLI_ERR_LEN      4'h9
`define ATCLI_BUF_DEPTH    2

`endif

// ==== src/atcli_pkg.sv ====
// Purpose: types for the command line interpreter
// Assumes: used by atcli_core only
// Notes:   parser states
package atcli_pkg;

    typedef enum logic [2:0] {
        PS_WAIT_A,
        PS_WAIT_T,
        PS_BODY,
        PS_EXEC,
        PS_RESP
    } atcli_pstate_e;

endpackage

// ==== src/atcli_core.sv ====
// Purpose: command line interpreter with on-line data pass-through
// Assumes: host characters arrive as valid/ready bytes on the system clock
// Notes:   executor outside decides command validity; the core answers overlong lines with error itself
`timescale 1ns/10ps
`include "atcli_cfg.svh"

module atcli_core #(
    parameter int LINE_DEPTH = `ATCLI_LINE_DEPTH,
    parameter int BUF_DEPTH  = `ATCLI_BUF_DEPTH
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // host receive stream
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    // host transmit stream
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    // alternate packet path into the parser
    input  wire logic [7:0] api_rx_data,
    input  wire logic       api_rx_valid,
    output logic            api_rx_ready,
    output logic [7:0]      api_tx_data,
    output logic            api_tx_valid,
    input  wire logic       api_tx_ready,
    // call data towards the network
    output logic [7:0]      dl_data,
    output logic            dl_valid,
    input  wire logic       dl_ready,
    // call data from the network
    input  wire logic [7:0] ul_data,
    input  wire logic       ul_valid,
    output logic            ul_ready,
    // call status
    input  wire logic       call_connect,
    input  wire logic       call_drop,
    output logic            online,
    // command executor
    output logic            cmd_req,
    output logic [7:0]      cmd_len,
    input  wire logic [7:0] cmd_rd_idx,
    output logic [7:0]      cmd_rd_char,
    input  wire logic       cmd_done,
    input  wire logic       cmd_ok,
    // unsolicited reports
    input  wire logic [7:0] urc_data,
    input  wire logic       urc_valid,
    input  wire logic       urc_last,
    output logic            urc_ready
);

    localparam int LW = $clog2(LINE_DEPTH + 1);
    localparam int LI = (LINE_DEPTH > 1) ? $clog2(LINE_DEPTH) : 1;
    localparam int BI = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int BW = $clog2(BUF_DEPTH + 1);

    function automatic logic [7:0] to_upper(input logic [7:0] c);
        if (c >= `ATCLI_CH_LOW_A && c <= `ATCLI_CH_LOW_Z) begin
            return c - `ATCLI_CASE_OFFSET;
        end
        return c;
    endfunction

    function automatic logic [7:0] resp_char(input logic ok, input logic [3:0] i);
        logic [71:0] err_txt;
        logic [47:0] ok_txt;
        err_txt = `ATCLI_ERR_TEXT;
        ok_txt  = `ATCLI_OK_TEXT;
        if (ok) begin
            return ok_txt[8*(`ATCLI_OK_LEN - 4'h1 - i) +: 8];
        end
        return err_txt[8*(`ATCLI_ERR_LEN - 4'h1 - i) +: 8];
    endfunction

    // parser state
    atcli_pkg::atcli_pstate_e state_reg, state_next;
    logic [LW-1:0] len_reg, len_next;
    logic          ovf_reg, ovf_next;
    logic          quote_reg, quote_next;
    logic          resp_ok_reg, resp_ok_next;
    logic [3:0]    resp_idx_reg, resp_idx_next;
    logic          cmd_req_reg;
    logic [7:0]    line_mem [LINE_DEPTH];
    // mode and escape
    logic          online_reg, online_next;
    logic [1:0]    plus_cnt_reg, plus_cnt_next;
    logic          urc_busy_reg, urc_busy_next;
    // two-entry data buffer
    logic [7:0]    buf_mem [BUF_DEPTH];
    logic [BI-1:0] buf_wr_reg, buf_rd_reg;
    logic [BW-1:0] buf_cnt_reg;

    // parser input selection
    wire        p_in_valid = online_reg ? api_rx_valid : rx_valid;
    wire [7:0]  p_in_data  = online_reg ? api_rx_data : rx_data;
    wire [7:0]  p_up       = to_upper(p_in_data);
    // parser keeps taking characters in every mode
    wire        p_in_ready = (state_reg == atcli_pkg::PS_WAIT_A) ||
                             (state_reg == atcli_pkg::PS_WAIT_T) ||
                             (state_reg == atcli_pkg::PS_BODY);
    wire        p_take     = p_in_valid && p_in_ready;
    wire        is_cr      = (p_in_data == `ATCLI_CH_CR);
    wire        line_full  = (len_reg == LW'(LINE_DEPTH));
    wire        is_quote   = (p_in_data == `ATCLI_CH_QUOTE);
    wire [7:0]  store_char = quote_reg ? p_in_data : p_up;
    wire        store_en   = p_take && (state_reg == atcli_pkg::PS_BODY) &&
                             !is_cr && !line_full;

    // response path and arbitration
    wire [3:0]  resp_len   = resp_ok_reg ? `ATCLI_OK_LEN : `ATCLI_ERR_LEN;
    wire [7:0]  resp_data  = resp_char(resp_ok_reg, resp_idx_reg);
    wire        in_resp    = (state_reg == atcli_pkg::PS_RESP);
    wire        resp_host  = !online_reg && in_resp && !urc_busy_reg;
    wire        resp_ready = online_reg ? api_tx_ready : (resp_host && tx_ready);
    wire        resp_fire  = in_resp && resp_ready && (online_reg || resp_host);
    wire        resp_last  = (resp_idx_reg == resp_len - 4'h1);
    // reports go out in command mode whenever no response is mid-flight
    wire        urc_go     = !online_reg && (urc_busy_reg || !in_resp);
    wire        urc_fire   = urc_go && urc_valid && tx_ready;

    // on-line pass-through
    wire        buf_full   = (buf_cnt_reg == BW'(BUF_DEPTH));
    wire        buf_push   = online_reg && rx_valid && !buf_full;
    wire        buf_pop    = (buf_cnt_reg != '0) && dl_ready;
    wire        is_plus    = (rx_data == `ATCLI_CH_PLUS);
    wire        esc_hit    = buf_push && is_plus &&
                             (plus_cnt_reg == `ATCLI_ESC_COUNT - 2'h1);

    // host characters feed the parser in command state
    assign rx_ready     = online_reg ? !buf_full : p_in_ready;
    assign api_rx_ready = online_reg && p_in_ready;
    assign api_tx_data  = resp_data;
    assign api_tx_valid = online_reg && in_resp;
    assign ul_ready     = online_reg && tx_ready;
    assign urc_ready    = urc_go && tx_ready;
    assign tx_valid     = online_reg ? ul_valid : (resp_host || (urc_go && urc_valid));
    assign tx_data      = online_reg ? ul_data : (resp_host ? resp_data : urc_data);
    assign dl_valid     = (buf_cnt_reg != '0);
    assign dl_data      = buf_mem[buf_rd_reg];
    assign online       = online_reg;
    assign cmd_req      = cmd_req_reg;
    assign cmd_len      = 8'(len_reg);
    assign cmd_rd_char  = (cmd_rd_idx < 8'(LINE_DEPTH)) ? line_mem[LI'(cmd_rd_idx)] : 8'h00;

    always_comb begin
        state_next    = state_reg;
        len_next      = len_reg;
        ovf_next      = ovf_reg;
        quote_next    = quote_reg;
        resp_ok_next  = resp_ok_reg;
        resp_idx_next = resp_idx_reg;
        case (state_reg)
            atcli_pkg::PS_WAIT_A: begin
                // prefix matched without regard to case
                if (p_take && p_up == `ATCLI_CH_A) begin
                    state_next = atcli_pkg::PS_WAIT_T;
                end
            end
            atcli_pkg::PS_WAIT_T: begin
                // prefix completes and opens the body
                if (p_take) begin
                    if (p_up == `ATCLI_CH_T) begin
                        state_next = atcli_pkg::PS_BODY;
                        len_next   = '0;
                        ovf_next   = 1'b0;
                        quote_next = 1'b0;
                    end else if (p_up != `ATCLI_CH_A) begin
                        state_next = atcli_pkg::PS_WAIT_A;
                    end
                end
            end
            atcli_pkg::PS_BODY: begin
                if (p_take) begin
                    if (is_cr) begin
                        if (ovf_reg) begin
                            state_next    = atcli_pkg::PS_RESP;
                            resp_ok_next  = 1'b0;
                            resp_idx_next = 4'h0;
                        end else begin
                            state_next = atcli_pkg::PS_EXEC;
                        end
                    end else if (line_full) begin
                        ovf_next = 1'b1;
                    end else begin
                        len_next = len_reg + LW'(1);
                        if (is_quote) begin
                            quote_next = !quote_reg;
                        end
                    end
                end
            end
            atcli_pkg::PS_EXEC: begin
                if (cmd_done) begin
                    state_next    = atcli_pkg::PS_RESP;
                    resp_ok_next  = cmd_ok;
                    resp_idx_next = 4'h0;
                end
            end
            atcli_pkg::PS_RESP: begin
                // result text sent for each line
                if (resp_fire) begin
                    resp_idx_next = resp_idx_reg + 4'h1;
                    if (resp_last) begin
                        state_next = atcli_pkg::PS_WAIT_A;
                    end
                end
            end
            default: state_next = atcli_pkg::PS_WAIT_A;
        endcase
    end

    always_comb begin
        online_next   = online_reg;
        plus_cnt_next = plus_cnt_reg;
        urc_busy_next = urc_busy_reg;
        if (buf_push) begin
            plus_cnt_next = is_plus ? plus_cnt_reg + 2'h1 : 2'h0;
        end
        // escape leaves the call up, only mode changes
        if (esc_hit) begin
            online_next   = 1'b0;
            plus_cnt_next = 2'h0;
        end
        if (call_drop) begin
            online_next = 1'b0;
        end
        // established call switches to data pass-through
        if (call_connect) begin
            online_next   = 1'b1;
            plus_cnt_next = 2'h0;
        end
        if (urc_fire) begin
            urc_busy_next = !urc_last;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= atcli_pkg::PS_WAIT_A;
            len_reg      <= '0;
            ovf_reg      <= 1'b0;
            quote_reg    <= 1'b0;
            resp_ok_reg  <= 1'b0;
            resp_idx_reg <= 4'h0;
            cmd_req_reg  <= 1'b0;
            online_reg   <= 1'b0;
            plus_cnt_reg <= 2'h0;
            urc_busy_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            len_reg      <= len_next;
            ovf_reg      <= ovf_next;
            quote_reg    <= quote_next;
            resp_ok_reg  <= resp_ok_next;
            resp_idx_reg <= resp_idx_next;
            cmd_req_reg  <= (state_reg != atcli_pkg::PS_EXEC) &&
                            (state_next == atcli_pkg::PS_EXEC);
            online_reg   <= online_next;
            plus_cnt_reg <= plus_cnt_next;
            urc_busy_reg <= urc_busy_next;
        end
    end

    // body stored in upper case, quoted text kept as sent
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < LINE_DEPTH; i++) begin
                line_mem[i] <= 8'h00;
            end
        end else if (store_en) begin
            line_mem[LI'(len_reg)] <= store_char;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            buf_wr_reg  <= '0;
            buf_rd_reg  <= '0;
            buf_cnt_reg <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= 8'h00;
            end
        end else begin
            if (buf_push) begin
                buf_mem[buf_wr_reg] <= rx_data;
                buf_wr_reg <= (buf_wr_reg == BI'(BUF_DEPTH - 1)) ? '0 : buf_wr_reg + BI'(1);
            end
            if (buf_pop) begin
                buf_rd_reg <= (buf_rd_reg == BI'(BUF_DEPTH - 1)) ? '0 : buf_rd_reg + BI'(1);
            end
            buf_cnt_reg <= buf_cnt_reg + BW'(buf_push) - BW'(buf_pop);
        end
    end

endmodule

// ==== tb/atcli_props.sv ====
// Purpose: port assertions for the command line interpreter
// Assumes: one clock, reset_n asynchronous active low
// Notes:   bound to atcli_core from tb_top
`timescale 1ns/10ps

module atcli_props #(
    parameter int LINE_DEPTH = 64
) (
    // watched ports
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       api_rx_ready,
    input wire logic [7:0] dl_data,
    input wire logic       dl_valid,
    input wire logic       dl_ready,
    input wire logic [7:0] ul_data,
    input wire logic       ul_valid,
    input wire logic       ul_ready,
    input wire logic       call_connect,
    input wire logic       call_drop,
    input wire logic       online,
    input wire logic       cmd_req,
    input wire logic [7:0] cmd_len,
    input wire logic       cmd_done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [1:0] plus_reg;
    wire        push = online && rx_valid && rx_ready;
    // consecutive plus bytes pushed while on-line
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) plus_reg <= 2'h0;
        else if (!online) plus_reg <= 2'h0;
        else if (push) plus_reg <= (rx_data == 8'h2b) ? plus_reg + 2'h1 : 2'h0;
    end
    a_online_enter: assert property (call_connect |=> online)
        else $error("online not set after connect");
    a_escape_leave: assert property (
        (push && rx_data == 8'h2b && plus_reg == 2'h2 && !call_connect) |=> !online)
        else $error("escape did not leave on-line mode");
    a_drop_leave: assert property ((call_drop && !call_connect) |=> !online)
        else $error("call drop did not leave on-line mode");
    a_push_fwd: assert property (push |=> dl_valid)
        else $error("pushed byte not offered");
    a_dl_hold: assert property ((dl_valid && !dl_ready) |=> (dl_valid && $stable(dl_data)))
        else $error("call data dropped while stalled");
    a_ul_pass: assert property (
        (online && ul_valid && tx_ready) |-> (ul_ready && tx_valid && tx_data == ul_data))
        else $error("call data not passed to host");
    a_cmd_quiet: assert property (!online |-> (!ul_ready && !api_rx_ready))
        else $error("data path open in command mode");
    a_req_pulse: assert property (
        cmd_req |-> (online ? !api_rx_ready : !rx_ready) ##1 !cmd_req)
        else $error("request not a closed pulse");
    a_req_len: assert property (cmd_req |-> cmd_len <= LINE_DEPTH)
        else $error("request longer than line store");
    a_resp_first: assert property (
        (!online && cmd_done) |=> (tx_valid && tx_data == 8'h0d))
        else $error("response did not start with carriage return");
endmodule

// ==== tb/atcli_host.sv ====
// Purpose: host application model on the serial stream
// Assumes: bytes handed over with valid/ready
// Notes:   free receive stalls from its own seed
`timescale 1ns/10ps
`include "atcli_cfg.svh"

module atcli_host (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // serial stream
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    int seed = 24681;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    always @(posedge clock) #1 tx_ready = ($random(seed) % 4) != 0;
    task automatic put(input logic [7:0] b);
        logic h;
        rx_data = b;
        rx_valid = 1'b1;
        do begin
            @(negedge clock) h = rx_ready;
            @(posedge clock);
        end while (h !== 1'b1);
        #1;
    endtask
    // released line shows no stale byte
    task automatic idle;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
    task automatic line(input string s);
        foreach (s[i]) put(s[i]);
        put(`ATCLI_CH_CR);
        idle();
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the command line interpreter
// Assumes: host model drives the serial stream, bench plays executor
// Notes:   drivers queue expected bytes, monitors compare them
`timescale 1ns/10ps
`include "atcli_cfg.svh"

module tb_top;
    localparam int LD = 8;
    logic       clock, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, api_rx_valid;
    logic       api_rx_ready, api_tx_valid, api_tx_ready, dl_valid, dl_ready, ul_valid;
    logic       ul_ready, call_connect, call_drop, online, cmd_req, cmd_done, cmd_ok;
    logic       urc_valid, urc_last, urc_ready, ok_flag, dl_hold, h;
    logic [7:0] rx_data, tx_data, api_rx_data, api_tx_data, dl_data, ul_data;
    logic [7:0] cmd_len, cmd_rd_idx, cmd_rd_char, urc_data, b;
    logic [7:0] q_tx[$], q_api[$], q_dl[$];
    int         fail_count, n_compared, seed;
    string      body, s;
    atcli_host host_u (.clock, .reset_n, .rx_data, .rx_valid, .rx_ready, .tx_data,
        .tx_valid, .tx_ready);
    atcli_core #(.LINE_DEPTH(LD)) dut_u (.clock, .reset_n, .rx_data, .rx_valid,
        .rx_ready, .tx_data, .tx_valid, .tx_ready, .api_rx_data, .api_rx_valid,
        .api_rx_ready, .api_tx_data, .api_tx_valid, .api_tx_ready, .dl_data, .dl_valid,
        .dl_ready, .ul_data, .ul_valid, .ul_ready, .call_connect, .call_drop, .online,
        .cmd_req, .cmd_len, .cmd_rd_idx, .cmd_rd_char, .cmd_done, .cmd_ok, .urc_data,
        .urc_valid, .urc_last, .urc_ready);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic take(input logic [7:0] got, ref logic [7:0] q[$]);
        if (q.size() == 0) begin
            n_compared++;
            fail_count++;
            $display("mismatch at %0t: unexpected byte %h", $time, got);
        end else begin
            chk(got, q.pop_front());
        end
    endtask
    task automatic push_resp(input logic ok, ref logic [7:0] q[$]);
        logic [71:0] t;
        t = ok ? {24'h0, `ATCLI_OK_TEXT} : `ATCLI_ERR_TEXT;
        for (int i = (ok ? `ATCLI_OK_LEN : `ATCLI_ERR_LEN) - 1; i >= 0; i--) begin
            q.push_back(t[8*i+:8]);
        end
    endtask
    task automatic run_cmd(input string ln, input string bd, input logic ok);
        body = bd;
        ok_flag = ok;
        push_resp(ok, q_tx);
        host_u.line(ln);
        while (q_tx.size() != 0) @(posedge clock);
        #1;
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        #1 ul_data = 8'($random(seed));
        dl_ready = !dl_hold && ($random(seed) & 1);
    end
    always @(negedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1 && online !== 1'b1)
            take(tx_data, q_tx);
        if (api_tx_valid === 1'b1 && api_tx_ready === 1'b1) take(api_tx_data, q_api);
        if (dl_valid === 1'b1 && dl_ready === 1'b1) take(dl_data, q_dl);
    end
    // executor: checks the stored line, then gives its verdict
    initial forever begin
        @(negedge clock);
        if (cmd_req === 1'b1) begin
            chk(cmd_len, 8'(body.len()));
            for (int i = 0; i < body.len(); i++) begin
                @(posedge clock) #1 cmd_rd_idx = 8'(i);
                @(negedge clock) chk(cmd_rd_char, body[i]);
            end
            @(posedge clock) #1 {cmd_done, cmd_ok} = {1'b1, ok_flag};
            @(posedge clock) #1 cmd_done = 1'b0;
        end
    end
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial begin
        seed = 24681;
        {fail_count, n_compared} = '0;
        {reset_n, api_rx_valid, ul_valid, call_connect, call_drop, cmd_done, cmd_ok} = '0;
        {urc_valid, urc_last, dl_hold, ok_flag} = '0;
        {api_rx_data, cmd_rd_idx, urc_data} = '0;
        api_tx_ready = 1'b1;
        repeat (3) @(posedge clock);
        #1 reset_n = 1'b1;
        run_cmd("at+c\"ab\"", "+C\"ab\"", 1'b1);
        run_cmd("AtZq", "ZQ", 1'b0);
        run_cmd("at12345678", "12345678", 1'b1);
        run_cmd("at123456789", "123456789", 1'b0);
        for (int i = 0; i < 3; i++) begin
            urc_data = 8'($random(seed));
            urc_valid = 1'b1;
            urc_last = (i == 2);
            q_tx.push_back(urc_data);
            do begin
                @(negedge clock) h = urc_ready;
                @(posedge clock);
            end while (h !== 1'b1);
            #1;
        end
        urc_valid = 1'b0;
        call_connect = 1'b1;
        @(posedge clock) #1 call_connect = 1'b0;
        ul_valid = 1'b1;
        body = "";
        ok_flag = 1'b1;
        push_resp(1'b1, q_api);
        s = "AT\015";
        foreach (s[i]) begin
            api_rx_data = s[i];
            api_rx_valid = 1'b1;
            do begin
                @(negedge clock) h = api_rx_ready;
                @(posedge clock);
            end while (h !== 1'b1);
            #1;
        end
        api_rx_valid = 1'b0;
        while (q_api.size() != 0) @(posedge clock);
        #1 dl_hold = 1'b1;
        fork
            for (int i = 0; i < 4; i++) begin
                b = 8'($random(seed));
                if (b == 8'h2b) b = 8'h2a;
                q_dl.push_back(b);
                host_u.put(b);
            end
            begin
                repeat (12) @(negedge clock);
                chk(rx_ready, 1'b0);
                dl_hold = 1'b0;
            end
        join
        s = "++A+++";
        foreach (s[i]) begin
            q_dl.push_back(s[i]);
            host_u.put(s[i]);
            if (i == 3) chk(online, 1'b1);
        end
        host_u.idle();
        ul_valid = 1'b0;
        @(posedge clock) #1 chk(online, 1'b0);
        run_cmd("aT", "", 1'b1);
        // dropped call leaves on-line mode
        call_connect = 1'b1;
        @(posedge clock) #1 {call_connect, call_drop} = 2'b01;
        chk(online, 1'b1);
        @(posedge clock) #1 call_drop = 1'b0;
        chk(online, 1'b0);
        while (q_dl.size() != 0) @(posedge clock);
        complete_run();
    end
endmodule

bind atcli_core atcli_props #(.LINE_DEPTH(LINE_DEPTH)) props_u (.clock, .reset_n, .rx_data,
    .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .api_rx_ready, .dl_data, .dl_valid,
    .dl_ready, .ul_data, .ul_valid, .ul_ready, .call_connect, .call_drop, .online,
    .cmd_req, .cmd_len, .cmd_done);
